// [hdl/odf_pkg.sv]
// package: constants shared by the octal decimation filter
package odf_pkg;
    // ----------------------------------------
    // channels and result format
    // ----------------------------------------
    localparam int NUM_CHANNELS = 8;
    localparam int RESULT_WIDTH = 24;
    localparam logic [23:0] CODE_MAX = 24'h7fffff;
    localparam logic [23:0] CODE_MIN = 24'h800000;
    // ----------------------------------------
    // mode-select codes
    // ----------------------------------------
    typedef enum logic [1:0] {
        ODF_HIGH_SPEED = 2'h0,
        ODF_HIGH_RES = 2'h1,
        ODF_LOW_POWER = 2'h2,
        ODF_LOW_SPEED = 2'h3
    } odf_mode_e;
    // ----------------------------------------
    // decimation ratios and modulator dividers
    // ----------------------------------------
    localparam int OSR_NORMAL = 64;
    localparam int OSR_HIGH_RES = 128;
    localparam int DIV_4 = 4;
    localparam int DIV_8 = 8;
    localparam int DIV_40 = 40;
    localparam int DIV_CNT_WIDTH = 6;
    localparam int DEC_CNT_WIDTH = 7;
    // ----------------------------------------
    // settling in conversion periods
    // ----------------------------------------
    localparam int SETTLE_NORMAL = 76;
    localparam int SETTLE_HIGH_RES = 78;
    localparam int SETTLE_CNT_WIDTH = 7;
    // accumulator width: cic3 gain 128^3 = 2^21 over 1-bit input
    localparam int ACC_WIDTH = 26;
endpackage

// [hdl/odf_channel.sv]
// module: one decimation channel, third-order sinc with saturating output
`timescale 1ns/100ps
module odf_channel #(
    parameter int ACC_W = odf_pkg::ACC_WIDTH,
    parameter int OUT_W = odf_pkg::RESULT_WIDTH
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic mod_bit_i,
    input wire logic sample_i,
    input wire logic dump_i,
    input wire logic high_res_i,
    output logic [OUT_W-1:0] result_o
);
    // ----------------------------------------
    // integrators and combs
    // ----------------------------------------
    logic signed [ACC_W-1:0] i1_q, i2_q, i3_q, i1_d, i2_d, i3_d;
    logic signed [ACC_W-1:0] c1_q, c2_q, c3_q, c1_d, c2_d, c3_d;
    logic [OUT_W-1:0] res_q, res_d;
    logic signed [ACC_W-1:0] x, d1, d2, d3;
    // five bits of headroom for the shift: stale comb state after a restart can put the
    // difference far past full scale, and the clamp must still land on the correct side
    logic signed [ACC_W+4:0] scaled;

    // next-state of the filter chain
    always_comb
    begin
        // bitstream maps to +1 / -1
        x = mod_bit_i ? ACC_W'(1) : -ACC_W'(1);
        i1_d = i1_q;
        i2_d = i2_q;
        i3_d = i3_q;
        c1_d = c1_q;
        c2_d = c2_q;
        c3_d = c3_q;
        res_d = res_q;
        d1 = i3_q - c1_q;
        d2 = d1 - c2_q;
        d3 = d2 - c3_q;
        // normalise to full scale: gain 2^18 or 2^21, result needs 2^23
        scaled = high_res_i ? ((ACC_W+5)'(d3) <<< 2) : ((ACC_W+5)'(d3) <<< 5);
        if (sample_i)
        begin
            // wrap-around integrators are exact for sinc filters
            i1_d = i1_q + x;
            i2_d = i2_q + i1_q;
            i3_d = i3_q + i2_q;
        end
        if (dump_i)
        begin
            c1_d = i3_q;
            c2_d = d1;
            c3_d = d2;
            // positive full-scale input overshoots by one lsb: clamp both ends
            if (scaled > $signed({{(ACC_W+5-OUT_W){1'b0}}, odf_pkg::CODE_MAX}))
                res_d = odf_pkg::CODE_MAX;
            else if (scaled < $signed({{(ACC_W+5-OUT_W){1'b1}}, odf_pkg::CODE_MIN}))
                res_d = odf_pkg::CODE_MIN;
            else
                res_d = scaled[OUT_W-1:0];
        end
    end

    // registers
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            i1_q <= '0;
            i2_q <= '0;
            i3_q <= '0;
            c1_q <= '0;
            c2_q <= '0;
            c3_q <= '0;
            res_q <= '0;
        end
        else
        begin
            i1_q <= i1_d;
            i2_q <= i2_d;
            i3_q <= i3_d;
            c1_q <= c1_d;
            c2_q <= c2_d;
            c3_q <= c3_d;
            res_q <= res_d;
        end
    end

    assign result_o = res_q;
endmodule // odf_channel

// [hdl/odf_filter_top.sv]
// module: octal decimation filter with mode pins, bypass, sync and output buffer
// Behaviour
// - eight channels, each filtered to 24 bits
// - four selectable operating modes
// - ratio 64 in three modes
// - ratio 128 in high-resolution mode
// - high-speed mode gives the top rate
// - bypass presents raw modulator bits
// - configured only by static pins
// - external sync aligns several devices
// - all channels share clock and start
// - stop band attenuated by filter chain
// - modulator divider from mode and divide pin
// - two's complement results, saturated at limits
// - settled flag after 76 or 78 periods
`timescale 1ns/100ps
module odf_filter_top #(
    parameter int NCH = odf_pkg::NUM_CHANNELS,
    parameter int W = odf_pkg::RESULT_WIDTH
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [1:0] mode_select_i,
    input wire logic clock_divide_select_i,
    input wire logic bypass_i,
    input wire logic sync_n_i,
    input wire logic [NCH-1:0] mod_bits_i,
    output logic modulator_sample_o,
    output logic [NCH-1:0] bypass_bits_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [NCH*W-1:0] out_data_o,
    output logic settled_o,
    output logic overflow_o
);
    // ----------------------------------------
    // pin synchronisers (configuration pins, sync and modulator bits)
    // ----------------------------------------
    logic [1:0] mode_s1_q, mode_s2_q;
    logic div_s1_q, div_s2_q, byp_s1_q, byp_s2_q, sync_s1_q, sync_s2_q, sync_prev_q;
    logic [NCH-1:0] bits_s1_q, bits_s2_q;

    // two flops on every pin but reset_n_i and out_ready_i before logic sees it
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mode_s1_q <= 2'h0;
            mode_s2_q <= 2'h0;
            div_s1_q <= 1'b0;
            div_s2_q <= 1'b0;
            byp_s1_q <= 1'b0;
            byp_s2_q <= 1'b0;
            sync_s1_q <= 1'b1;
            sync_s2_q <= 1'b1;
            sync_prev_q <= 1'b1;
            bits_s1_q <= '0;
            bits_s2_q <= '0;
        end
        else
        begin
            mode_s1_q <= mode_select_i;
            mode_s2_q <= mode_s1_q;
            div_s1_q <= clock_divide_select_i;
            div_s2_q <= div_s1_q;
            byp_s1_q <= bypass_i;
            byp_s2_q <= byp_s1_q;
            sync_s1_q <= sync_n_i;
            sync_s2_q <= sync_s1_q;
            sync_prev_q <= sync_s2_q;
            bits_s1_q <= mod_bits_i;
            bits_s2_q <= bits_s1_q;
        end
    end

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    odf_pkg::odf_mode_e mode;
    logic high_res;
    logic [odf_pkg::DIV_CNT_WIDTH-1:0] div_last;
    logic [odf_pkg::DEC_CNT_WIDTH-1:0] dec_last;
    logic [odf_pkg::SETTLE_CNT_WIDTH-1:0] settle_last;
    logic sync_hold, sync_rise;

    // divider, ratio and settling depend only on the two mode pins and divide pin
    always_comb
    begin
        mode = odf_pkg::odf_mode_e'(mode_s2_q);
        high_res = (mode == odf_pkg::ODF_HIGH_RES);
        unique case (mode)
            odf_pkg::ODF_HIGH_SPEED: div_last = odf_pkg::DIV_CNT_WIDTH'(odf_pkg::DIV_4 - 1);
            odf_pkg::ODF_HIGH_RES: div_last = odf_pkg::DIV_CNT_WIDTH'(odf_pkg::DIV_4 - 1);
            odf_pkg::ODF_LOW_POWER: div_last = div_s2_q ? odf_pkg::DIV_CNT_WIDTH'(odf_pkg::DIV_8 - 1)
                                                        : odf_pkg::DIV_CNT_WIDTH'(odf_pkg::DIV_4 - 1);
            odf_pkg::ODF_LOW_SPEED: div_last = div_s2_q ? odf_pkg::DIV_CNT_WIDTH'(odf_pkg::DIV_40 - 1)
                                                        : odf_pkg::DIV_CNT_WIDTH'(odf_pkg::DIV_8 - 1);
        endcase
        dec_last = high_res ? odf_pkg::DEC_CNT_WIDTH'(odf_pkg::OSR_HIGH_RES - 1)
                            : odf_pkg::DEC_CNT_WIDTH'(odf_pkg::OSR_NORMAL - 1);
        settle_last = high_res ? odf_pkg::SETTLE_CNT_WIDTH'(odf_pkg::SETTLE_HIGH_RES)
                               : odf_pkg::SETTLE_CNT_WIDTH'(odf_pkg::SETTLE_NORMAL);
        // sync held low freezes timing; its release restarts every channel together
        sync_hold = !sync_s2_q;
        sync_rise = sync_s2_q && !sync_prev_q;
    end

    // ----------------------------------------
    // shared timing: one divider and one decimation counter
    // ----------------------------------------
    logic [odf_pkg::DIV_CNT_WIDTH-1:0] div_q, div_d;
    logic [odf_pkg::DEC_CNT_WIDTH-1:0] dec_q, dec_d;
    logic [odf_pkg::SETTLE_CNT_WIDTH-1:0] settle_q, settle_d;
    logic sample, dump, restart;

    // next values of the shared counters
    always_comb
    begin
        restart = sync_hold || sync_rise;
        sample = !restart && (div_q == div_last);
        dump = sample && (dec_q == dec_last);
        div_d = div_q;
        dec_d = dec_q;
        settle_d = settle_q;
        if (restart)
        begin
            // counters restart so that all channels convolve from one cycle
            div_d = '0;
            dec_d = '0;
            settle_d = '0;
        end
        else if (div_q >= div_last)
        begin
            // >= also recovers when the mode pins shrink the divider mid-count
            div_d = '0;
            dec_d = (dec_q >= dec_last) ? '0 : dec_q + 1'b1;
            if (dump && settle_q != settle_last)
                settle_d = settle_q + 1'b1;
        end
        else
        begin
            div_d = div_q + 1'b1;
        end
    end

    // counter registers
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            div_q <= '0;
            dec_q <= '0;
            settle_q <= '0;
        end
        else
        begin
            div_q <= div_d;
            dec_q <= dec_d;
            settle_q <= settle_d;
        end
    end

    // ----------------------------------------
    // eight channel filters
    // ----------------------------------------
    logic [NCH*W-1:0] results;
    logic [NCH-1:0] bypass_q, bypass_d;
    logic dump_q, dump_d;

    for (genvar ch = 0; ch < NCH; ch++)
    begin : g_chan
        odf_channel #(
            .ACC_W(odf_pkg::ACC_WIDTH),
            .OUT_W(W)
        ) u_chan (
            .sys_clk_i(sys_clk_i),
            .reset_n_i(reset_n_i),
            .mod_bit_i(bits_s2_q[ch]),
            .sample_i(sample),
            .dump_i(dump),
            .high_res_i(high_res),
            .result_o(results[ch*W +: W])
        );
    end

    // ----------------------------------------
    // bypass path and two-entry output buffer
    // ----------------------------------------
    logic [NCH*W-1:0] buf0_q, buf0_d, buf1_q, buf1_d;
    logic [1:0] cnt_q, cnt_d;
    logic ovf_q, ovf_d, push, pop;

    // next values: bypass register, buffer, overflow flag
    always_comb
    begin
        bypass_d = bypass_q;
        if (sample)
            bypass_d = bits_s2_q;
        // results land one cycle after the dump strobe
        dump_d = dump && !byp_s2_q;
        push = dump_q;
        pop = (cnt_q != 2'h0) && out_ready_i;
        buf0_d = buf0_q;
        buf1_d = buf1_q;
        cnt_d = cnt_q;
        ovf_d = ovf_q;
        if (pop)
        begin
            buf0_d = buf1_q;
            cnt_d = cnt_q - 2'h1;
        end
        if (push)
        begin
            // a full buffer drops the newest set and flags it, never tears a set
            if (cnt_d == 2'h2)
                ovf_d = 1'b1;
            else if (cnt_d == 2'h1)
            begin
                buf1_d = results;
                cnt_d = 2'h2;
            end
            else
            begin
                buf0_d = results;
                cnt_d = 2'h1;
            end
        end
        if (sync_rise)
            ovf_d = 1'b0;
    end

    // buffer and bypass registers
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            bypass_q <= '0;
            dump_q <= 1'b0;
            buf0_q <= '0;
            buf1_q <= '0;
            cnt_q <= 2'h0;
            ovf_q <= 1'b0;
        end
        else
        begin
            bypass_q <= bypass_d;
            dump_q <= dump_d;
            buf0_q <= buf0_d;
            buf1_q <= buf1_d;
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign modulator_sample_o = sample;
    assign bypass_bits_o = bypass_q;
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = buf0_q;
    assign settled_o = (settle_q == settle_last);
    assign overflow_o = ovf_q;
endmodule // odf_filter_top

// [testbench/odf_filter_top_properties.sv]
// checker: port properties of the octal decimation filter
`timescale 1ns/100ps
module odf_filter_top_properties #(
    parameter int NCH = odf_pkg::NUM_CHANNELS,
    parameter int W = odf_pkg::RESULT_WIDTH
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic sync_n_i,
    input wire logic modulator_sample_o,
    input wire logic [NCH-1:0] bypass_bits_o,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic [NCH*W-1:0] out_data_o,
    input wire logic overflow_o
);
    // ----------------------------------------
    // sync quiet counter
    // ----------------------------------------
    // sync acts through flops, so sticky checks wait until it has been high a while
    logic [2:0] quiet_q, quiet_d;
    always_comb
        quiet_d = !sync_n_i ? 3'h0 : (quiet_q == 3'h7 ? 3'h7 : quiet_q + 3'h1);
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
        if (!reset_n_i)
            quiet_q <= 3'h0;
        else
            quiet_q <= quiet_d;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    chk_pulse_gap: assert property (modulator_sample_o |=> !modulator_sample_o [*3])
        else $error("sample pulses closer than four cycles");
    chk_valid_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o)
        else $error("valid dropped without a pop");
    chk_data_hold: assert property (out_valid_o && !out_ready_i |=> $stable(out_data_o))
        else $error("data changed while stalled");
    chk_bypass_latch: assert property (!modulator_sample_o |=> $stable(bypass_bits_o))
        else $error("raw bits changed off a sample");
    chk_overflow_sticky: assert property (overflow_o && quiet_q == 3'h7 |=> overflow_o)
        else $error("overflow flag cleared without restart");
    chk_valid_rise: assert property ($rose(out_valid_o) |-> $past(modulator_sample_o, 2))
        else $error("result set not tied to a sample");
    chk_overflow_cause: assert property ($rose(overflow_o) |-> $past(out_valid_o))
        else $error("overflow with empty buffer");
    chk_valid_fall: assert property ($fell(out_valid_o) |-> $past(out_ready_i))
        else $error("valid fell without ready");
endmodule // odf_filter_top_properties
bind odf_filter_top odf_filter_top_properties #(.NCH(NCH), .W(W)) u_props (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .sync_n_i(sync_n_i),
    .modulator_sample_o(modulator_sample_o),
    .bypass_bits_o(bypass_bits_o),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_data_o),
    .overflow_o(overflow_o)
);

// [testbench/odf_host_model.sv]
// host model: takes each result set, may stall on request
`timescale 1ns/100ps
module odf_host_model #(
    parameter int DW = 192
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic stall_i,
    input wire logic out_valid_i,
    input wire logic [DW-1:0] out_data_i,
    output logic out_ready_o,
    output logic [DW-1:0] last_o,
    output int pops_o
);
    // ready every cycle unless stalled, so the top rate is kept up with
    assign out_ready_o = !stall_i;
    // capture the head on each pop
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
        if (!reset_n_i)
            pops_o <= 0;
        else if (out_valid_i && out_ready_o)
        begin
            pops_o <= pops_o + 1;
            last_o <= out_data_i;
        end
endmodule // odf_host_model

// [testbench/odf_filter_top_tb.sv]
// testbench: rates, settling, high resolution, overflow and bypass of the octal filter
`timescale 1ns/100ps
module odf_filter_top_tb;
    localparam int DW = odf_pkg::NUM_CHANNELS * odf_pkg::RESULT_WIDTH;
    logic sys_clk, reset_n, div_sel, bypass, sync_n, stall, ready;
    logic [1:0] mode;
    logic [7:0] mod_bits, byp_bits;
    logic sample, valid, settled, overflow;
    logic [DW-1:0] data, last;
    int pops, n_fail = 0, samples_checked = 0;
    odf_filter_top uut (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .mode_select_i(mode),
        .clock_divide_select_i(div_sel), .bypass_i(bypass), .sync_n_i(sync_n), .mod_bits_i(mod_bits),
        .modulator_sample_o(sample), .bypass_bits_o(byp_bits), .out_valid_o(valid), .out_ready_i(ready),
        .out_data_o(data), .settled_o(settled), .overflow_o(overflow));
    odf_host_model #(.DW(DW)) host (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .stall_i(stall),
        .out_valid_i(valid), .out_data_i(data), .out_ready_o(ready), .last_o(last), .pops_o(pops));
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked=%0d failed=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // inputs move 1 ns after the edge, away from sampling
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // mode and divide pins are static levels, changed only under a sync restart
    task automatic restart(input logic [1:0] m, input logic d);
        mode = m;
        div_sel = d;
        sync_n = 1'b0;
        tick(4);
        sync_n = 1'b1;
        tick(4);
    endtask
    task automatic gap(output int n);
        n = 0;
        do
        begin
            tick(1);
            n++;
        end while (sample !== 1'b1 && n < 100);
    endtask
    task automatic sets(input int k);
        int target;
        target = pops + k;
        for (int g = 0; g < 50000 && pops < target; g++)
            tick(1);
        // a wait that runs out counts as a mismatch
        check(DW'(pops), DW'(target));
    endtask
    task automatic t_rates();
        int n, c, base;
        logic [1:0] md [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
        logic dd [6] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
        logic [5:0] dv [6] = '{6'h04, 6'h04, 6'h08, 6'h04, 6'h28, 6'h08};
        for (int i = 0; i < 6; i++)
        begin
            restart(md[i], dd[i]);
            gap(n);
            gap(n);
            check(DW'(n), DW'(dv[i]));
            sets(1);
            base = pops;
            c = 0;
            for (int g = 0; g < 12000 && pops == base; g++)
            begin
                tick(1);
                if (sample === 1'b1)
                    c++;
            end
            check(DW'(c), md[i] == 2'h1 ? DW'(128) : DW'(64));
        end
        $display("t_rates done");
    endtask
    task automatic t_settle();
        logic [DW-1:0] e;
        for (int ch = 0; ch < 8; ch++)
            e[ch*24 +: 24] = ch[0] ? odf_pkg::CODE_MIN : odf_pkg::CODE_MAX;
        mod_bits = 8'h55;
        restart(2'h0, 1'h1);
        sets(75);
        check(DW'(settled), DW'(0));
        sets(1);
        tick(2);
        check(DW'(settled), DW'(1));
        check(last, e);
        mod_bits = 8'haa;
        sets(5);
        check(last, ~e);
        $display("t_settle done");
    endtask
    task automatic t_overflow();
        int base;
        mod_bits = 8'hff;
        // restart first, so the sets built on stale comb state drain before the stall
        restart(2'h0, 1'h1);
        sets(4);
        stall = 1'b1;
        base = pops;
        // dumps land 256, 512 and 768 cycles after the dump of the last popped set; the third is dropped
        tick(800);
        check(DW'({valid, overflow}), DW'(2'h3));
        check(data, {8{odf_pkg::CODE_MAX}});
        stall = 1'b0;
        tick(3);
        check(DW'(pops - base), DW'(2));
        check(DW'({valid, overflow}), DW'(2'h1));
        restart(2'h0, 1'h1);
        check(DW'(overflow), DW'(0));
        $display("t_overflow done");
    endtask
    task automatic t_highres();
        mod_bits = 8'h0f;
        restart(2'h1, 1'h1);
        sets(77);
        check(DW'(settled), DW'(0));
        sets(1);
        tick(2);
        check(DW'(settled), DW'(1));
        check(last, {{4{odf_pkg::CODE_MIN}}, {4{odf_pkg::CODE_MAX}}});
        $display("t_highres done");
    endtask
    task automatic t_bypass();
        int base;
        bypass = 1'b1;
        mod_bits = 8'h3c;
        restart(2'h0, 1'h1);
        base = pops;
        tick(700);
        check(DW'(byp_bits), DW'(8'h3c));
        check(DW'(pops - base), DW'(0));
        bypass = 1'b0;
        $display("t_bypass done");
    endtask
    initial
    begin
        {reset_n, sync_n, stall, bypass, div_sel} = 5'h09;
        mode = 2'h0;
        mod_bits = 8'h00;
        repeat (10) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        tick(4);
        t_rates();
        t_settle();
        t_overflow();
        t_highres();
        t_bypass();
        give_verdict();
    end
    // watchdog: the tests need about 73000 cycles
    initial
    begin
        repeat (90000) @(posedge sys_clk);
        n_fail++;
        give_verdict();
    end
endmodule // odf_filter_top_tb
